// [pbc_pkg.sv]
// Purpose: shared constants and types for the port B/C pin function block
// Assumes: 32-bit APB, one aligned word per register, 16-bit data in low bits
// Notes:   reserved bits are masked on write so that they always read zero
package pbc_pkg;

  // apb address width and register byte offsets
  localparam int          PBC_AW            = 8;
  localparam logic [7:0]  PBC_OFF_PA_FN     = 8'h00; // port a function lower
  localparam logic [7:0]  PBC_OFF_PB_DIR    = 8'h04; // port_b_direction
  localparam logic [7:0]  PBC_OFF_PB_FU     = 8'h08; // port_b_function_upper
  localparam logic [7:0]  PBC_OFF_PB_FL     = 8'h0C; // port_b_function_lower
  localparam logic [7:0]  PBC_OFF_PC_DIR    = 8'h10; // port_c_direction
  localparam logic [7:0]  PBC_OFF_PB_LEVEL  = 8'h14; // port b pin levels, ro
  localparam logic [7:0]  PBC_OFF_PC_LEVEL  = 8'h18; // port c pin levels, ro

  // writable bit masks, all other bits are reserved and read zero
  localparam logic [15:0] PBC_MASK_PA_FN    = 16'h0170;
  localparam logic [15:0] PBC_MASK_PB_DIR   = 16'h03FF;
  localparam logic [15:0] PBC_MASK_PB_FU    = 16'h000F;
  localparam logic [15:0] PBC_MASK_PB_FL    = 16'hF045;
  localparam logic [15:0] PBC_MASK_PC_DIR   = 16'hFFFF;

  // reset values, power-on only
  localparam logic [15:0] PBC_RST_REG       = 16'h0000;

  // pins present per port
  localparam logic [15:0] PBC_PINS_A        = 16'h001C; // pins 4..2
  localparam logic [15:0] PBC_PINS_B        = 16'h03FF; // pins 9..0
  localparam logic [15:0] PBC_PINS_C        = 16'hFFFF; // pins 15..0

  // field positions
  localparam int          PBC_PA4_FN        = 8;  // porta_pin4_function
  localparam int          PBC_PA3_FN        = 6;  // porta_pin3_function
  localparam int          PBC_PA2_FN_LO     = 4;  // porta_pin2_function_lo
  localparam int          PBC_PB9_FN_LO     = 2;  // portb_pin9_function_lo
  localparam int          PBC_PB8_FN_LO     = 0;  // portb_pin8_function_lo
  localparam int          PBC_PB7_FN_LO     = 14; // portb_pin7_function_lo
  localparam int          PBC_PB6_FN_LO     = 12; // portb_pin6_function_lo
  localparam int          PBC_PB3_FN        = 6;  // portb_pin3_function
  localparam int          PBC_PB1_FN        = 2;  // portb_pin1_function
  localparam int          PBC_PB0_FN        = 0;  // portb_pin0_function

  // two-bit function codes
  localparam logic [1:0]  PBC_FN_GPIO       = 2'h0;
  localparam logic [1:0]  PBC_FN_01         = 2'h1;
  localparam logic [1:0]  PBC_FN_10         = 2'h2;
  localparam logic [1:0]  PBC_FN_11         = 2'h3;

  // apb answer state, one-hot
  typedef enum logic [1:0] {
    PBC_IDLE = 2'b01,
    PBC_ACK  = 2'b10
  } pbc_apb_st_t;

  // one bit per pin lane of each port
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } pbc_pins_t;

  // peripheral signals going out onto pins
  typedef struct packed {
    logic txd;
    logic address_bit_sixteen;
    logic address_bit_seventeen;
    logic address_bit_eighteen;
    logic address_bit_nineteen;
    logic address_bit_twenty;
    logic address_bit_twentyone;
  } pbc_per_in_t;

  // pin inputs handed to peripherals, idle high
  typedef struct packed {
    logic rxd;
    logic interrupt_request_zero_n;
    logic interrupt_request_one_n;
    logic interrupt_request_six_n;
    logic interrupt_request_seven_n;
    logic wait_request_n;
  } pbc_per_out_t;

  localparam pbc_per_out_t PBC_PER_OUT_RST = 6'h3F;

  // software-visible registers
  typedef struct packed {
    logic [15:0] pa_fn;
    logic [15:0] pb_dir;
    logic [15:0] pb_fu;
    logic [15:0] pb_fl;
    logic [15:0] pc_dir;
  } pbc_regs_t;

  // whole state of the block
  typedef struct packed {
    pbc_apb_st_t  st;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    pbc_regs_t    regs;
    pbc_pins_t    sync1;
    pbc_pins_t    sync2;
    pbc_pins_t    pout;
    pbc_pins_t    poe;
    pbc_pins_t    din;
    pbc_per_out_t per;
  } pbc_state_t;

endpackage

// [pbc_pin_function.sv]
// Purpose: pin function and direction select for ports a (pins 4..2), b, c
// Assumes: presetn is the external power-on reset; pins are asynchronous
// Notes:   all outputs registered, so pins follow registers one cycle late
// How it works
// - pa4 bit 8 picks gpio or txd
// - pa3 bit 6 picks gpio or rxd
// - pa2 bits 5:4, 00 gpio, 11 interrupt_request_zero
// - reserved bits read zero, software writes zero
// - port b direction acts only in gpio
// - port b direction cleared by power-on only
// - port b function regs cleared by power-on only
// - pb9 code: gpio, interrupt_request_seven, address 21
// - pb8 code: gpio, interrupt_request_six, address 20, wait
// - pb7 code: gpio or address 19
// - pb6 code: gpio or address 18
// - pb3 bit 6 picks gpio or interrupt_request_one
// - pb1 bit 2 picks gpio or address 17
// - pb0 bit 0 picks gpio or address 16
// - port c direction acts only in gpio
// - port c direction cleared by power-on only
// - all registers are 16-bit read/write except the two read-only level registers
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module pbc_pin_function (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  pclk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output      logic [31:0]           prdata,
  output      logic                  pready,
  output      logic                  pslverr,
  input  wire pbc_pkg::pbc_pins_t    pin_in,
  output      pbc_pkg::pbc_pins_t    pin_out,
  output      pbc_pkg::pbc_pins_t    pin_oe,
  input  wire pbc_pkg::pbc_pins_t    gpio_dout,
  input  wire logic [15:0]           porta_dir,
  output      pbc_pkg::pbc_pins_t    gpio_din,
  input  wire pbc_pkg::pbc_per_in_t  per_in,
  output      pbc_pkg::pbc_per_out_t per_out
);

  pbc_pkg::pbc_state_t q;      // registered state
  pbc_pkg::pbc_state_t d;      // next state
  logic [15:0]         rd_val; // decoded read value
  logic                hit;    // address is mapped
  logic [1:0]          code;   // two-bit function field under test

  // outputs straight from flops
  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign pin_out = q.pout;
  assign pin_oe  = q.poe;
  assign gpio_din = q.din;
  assign per_out = q.per;

  // next-state logic: apb, synchronisers and pin mux
  always_comb begin
    d      = q;
    rd_val = 16'h0000;
    hit    = 1'b1;
    code   = 2'h0;

    // read decode, unmapped gives error and zero
    case (paddr)
      pbc_pkg::PBC_OFF_PA_FN:    rd_val = q.regs.pa_fn;
      pbc_pkg::PBC_OFF_PB_DIR:   rd_val = q.regs.pb_dir;
      pbc_pkg::PBC_OFF_PB_FU:    rd_val = q.regs.pb_fu;
      pbc_pkg::PBC_OFF_PB_FL:    rd_val = q.regs.pb_fl;
      pbc_pkg::PBC_OFF_PC_DIR:   rd_val = q.regs.pc_dir;
      pbc_pkg::PBC_OFF_PB_LEVEL: rd_val = q.sync2.b;
      pbc_pkg::PBC_OFF_PC_LEVEL: rd_val = q.sync2.c;
      default:                   hit    = 1'b0;
    endcase

    // apb: one wait state, write lands on the pready edge
    case (q.st)
      pbc_pkg::PBC_IDLE: begin
        if (psel && penable) begin
          d.st      = pbc_pkg::PBC_ACK;
          d.pready  = 1'b1;
          d.pslverr = ~hit;
          d.prdata  = pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
        end
      end
      pbc_pkg::PBC_ACK: begin
        d.st      = pbc_pkg::PBC_IDLE;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.prdata  = 32'h0000_0000;
        if (psel && penable && pwrite) begin
          // reserved bits masked so they stay zero
          case (paddr)
            pbc_pkg::PBC_OFF_PA_FN:
              d.regs.pa_fn = pwdata[15:0] & pbc_pkg::PBC_MASK_PA_FN;
            pbc_pkg::PBC_OFF_PB_DIR:
              d.regs.pb_dir = pwdata[15:0] & pbc_pkg::PBC_MASK_PB_DIR;
            pbc_pkg::PBC_OFF_PB_FU:
              d.regs.pb_fu = pwdata[15:0] & pbc_pkg::PBC_MASK_PB_FU;
            pbc_pkg::PBC_OFF_PB_FL:
              d.regs.pb_fl = pwdata[15:0] & pbc_pkg::PBC_MASK_PB_FL;
            pbc_pkg::PBC_OFF_PC_DIR:
              d.regs.pc_dir = pwdata[15:0] & pbc_pkg::PBC_MASK_PC_DIR;
            default: ; // read-only or unmapped: no effect
          endcase
        end
      end
      default: begin
        d.st     = pbc_pkg::PBC_IDLE;
        d.pready = 1'b0;
      end
    endcase

    // two-flop synchronisers on present pins only
    d.sync1.a = pin_in.a & pbc_pkg::PBC_PINS_A;
    d.sync1.b = pin_in.b & pbc_pkg::PBC_PINS_B;
    d.sync1.c = pin_in.c & pbc_pkg::PBC_PINS_C;
    d.sync2   = q.sync1;
    d.din     = q.sync2;

    // gpio default: data and direction per pin
    d.pout.a = gpio_dout.a & pbc_pkg::PBC_PINS_A;
    d.poe.a  = porta_dir & pbc_pkg::PBC_PINS_A;
    d.pout.b = gpio_dout.b & pbc_pkg::PBC_PINS_B;
    d.poe.b  = q.regs.pb_dir & pbc_pkg::PBC_PINS_B;
    d.pout.c = gpio_dout.c & pbc_pkg::PBC_PINS_C;
    d.poe.c  = q.regs.pc_dir & pbc_pkg::PBC_PINS_C;
    d.per    = pbc_pkg::PBC_PER_OUT_RST;

    // pa4: serial transmit drives the pin
    if (q.regs.pa_fn[pbc_pkg::PBC_PA4_FN]) begin
      d.pout.a[4] = per_in.txd;
      d.poe.a[4]  = 1'b1;
    end

    // pa3: pin feeds serial receive
    if (q.regs.pa_fn[pbc_pkg::PBC_PA3_FN]) begin
      d.pout.a[3] = 1'b0;
      d.poe.a[3]  = 1'b0;
      d.per.rxd   = q.sync2.a[3];
    end

    // pa2: interrupt_request_zero on code 11, reserved codes leave pin undriven
    code = q.regs.pa_fn[pbc_pkg::PBC_PA2_FN_LO +: 2];
    if (code != pbc_pkg::PBC_FN_GPIO) begin
      d.pout.a[2] = 1'b0;
      d.poe.a[2]  = 1'b0;
      if (code == pbc_pkg::PBC_FN_11)
        d.per.interrupt_request_zero_n = q.sync2.a[2];
    end

    // pb9: interrupt_request_seven or address 21
    code = q.regs.pb_fu[pbc_pkg::PBC_PB9_FN_LO +: 2];
    case (code)
      pbc_pkg::PBC_FN_01: begin
        d.pout.b[9] = 1'b0;
        d.poe.b[9]  = 1'b0;
        d.per.interrupt_request_seven_n = q.sync2.b[9];
      end
      pbc_pkg::PBC_FN_10: begin
        d.pout.b[9] = per_in.address_bit_twentyone;
        d.poe.b[9]  = 1'b1;
      end
      pbc_pkg::PBC_FN_11: begin
        d.pout.b[9] = 1'b0;                          // reserved code
        d.poe.b[9]  = 1'b0;
      end
      default: ;                                     // gpio
    endcase

    // pb8: interrupt_request_six, address 20 or wait input
    code = q.regs.pb_fu[pbc_pkg::PBC_PB8_FN_LO +: 2];
    case (code)
      pbc_pkg::PBC_FN_01: begin
        d.pout.b[8] = 1'b0;
        d.poe.b[8]  = 1'b0;
        d.per.interrupt_request_six_n = q.sync2.b[8];
      end
      pbc_pkg::PBC_FN_10: begin
        d.pout.b[8] = per_in.address_bit_twenty;
        d.poe.b[8]  = 1'b1;
      end
      pbc_pkg::PBC_FN_11: begin
        d.pout.b[8] = 1'b0;
        d.poe.b[8]  = 1'b0;
        d.per.wait_request_n = q.sync2.b[8];
      end
      default: ;                                     // gpio
    endcase

    // pb7: address 19, other codes reserved
    code = q.regs.pb_fl[pbc_pkg::PBC_PB7_FN_LO +: 2];
    if (code != pbc_pkg::PBC_FN_GPIO) begin
      d.pout.b[7] = (code == pbc_pkg::PBC_FN_10) ?
                    per_in.address_bit_nineteen : 1'b0;
      d.poe.b[7]  = (code == pbc_pkg::PBC_FN_10);
    end

    // pb6: address 18, other codes reserved
    code = q.regs.pb_fl[pbc_pkg::PBC_PB6_FN_LO +: 2];
    if (code != pbc_pkg::PBC_FN_GPIO) begin
      d.pout.b[6] = (code == pbc_pkg::PBC_FN_10) ?
                    per_in.address_bit_eighteen : 1'b0;
      d.poe.b[6]  = (code == pbc_pkg::PBC_FN_10);
    end

    // pb3: interrupt_request_one input
    if (q.regs.pb_fl[pbc_pkg::PBC_PB3_FN]) begin
      d.pout.b[3] = 1'b0;
      d.poe.b[3]  = 1'b0;
      d.per.interrupt_request_one_n = q.sync2.b[3];
    end

    // pb1: address 17 output
    if (q.regs.pb_fl[pbc_pkg::PBC_PB1_FN]) begin
      d.pout.b[1] = per_in.address_bit_seventeen;
      d.poe.b[1]  = 1'b1;
    end

    // pb0: address 16 output
    if (q.regs.pb_fl[pbc_pkg::PBC_PB0_FN]) begin
      d.pout.b[0] = per_in.address_bit_sixteen;
      d.poe.b[0]  = 1'b1;
    end
  end

  // state register: power-on reset only, frozen while pclk_en low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q      <= '0;
      q.st   <= pbc_pkg::PBC_IDLE;
      q.per  <= pbc_pkg::PBC_PER_OUT_RST;
    end else if (pclk_en) begin
      q <= d;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // write accepted at the pready edge
  sequence s_wr_take(logic [7:0] a);
    pclk_en && psel && penable && pready && pwrite && paddr == a;
  endsequence

  // setup then access phase
  sequence s_apb_start;
    pclk_en && psel && !penable && !pready ##1 pclk_en && psel && penable;
  endsequence

  property p_txd_route;
    pclk_en && q.regs.pa_fn[pbc_pkg::PBC_PA4_FN]
      |=> pin_out.a[4] == $past(per_in.txd) && pin_oe.a[4];
  endproperty
  a_txd_route: assert property (p_txd_route)
    else $error("pa4 not driven by txd");

  property p_rxd_route;
    pclk_en && q.regs.pa_fn[pbc_pkg::PBC_PA3_FN]
      |=> per_out.rxd == $past(q.sync2.a[3]) && !pin_oe.a[3];
  endproperty
  a_rxd_route: assert property (p_rxd_route)
    else $error("pa3 not routed to rxd");

  property p_interrupt_request_zero_route;
    pclk_en && q.regs.pa_fn[5:4] == pbc_pkg::PBC_FN_11
      |=> per_out.interrupt_request_zero_n == $past(q.sync2.a[2])
          && !pin_oe.a[2];
  endproperty
  a_interrupt_request_zero_route: assert property (p_interrupt_request_zero_route)
    else $error("pa2 not routed to interrupt_request_zero");

  property p_rsvd_zero;
    pclk_en && psel && penable && pready && !pwrite
      |-> prdata[31:16] == 16'h0000 && (paddr != pbc_pkg::PBC_OFF_PB_FU
          || prdata[15:4] == 12'h000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");

  property p_pb9_gpio_dir;
    pclk_en && q.regs.pb_fu[3:2] == pbc_pkg::PBC_FN_GPIO
      |=> pin_oe.b[9] == $past(q.regs.pb_dir[9]);
  endproperty
  a_pb9_gpio_dir: assert property (p_pb9_gpio_dir)
    else $error("pb9 direction not applied");

  property p_pb_dir_hold;
    pclk_en && !(psel && penable && pready && pwrite
                 && paddr == pbc_pkg::PBC_OFF_PB_DIR)
      |=> $stable(q.regs.pb_dir);
  endproperty
  a_pb_dir_hold: assert property (p_pb_dir_hold)
    else $error("port b direction changed without write");

  property p_pb_fu_write;
    s_wr_take(pbc_pkg::PBC_OFF_PB_FU)
      |=> q.regs.pb_fu == ($past(pwdata[15:0]) & pbc_pkg::PBC_MASK_PB_FU);
  endproperty
  a_pb_fu_write: assert property (p_pb_fu_write)
    else $error("port b upper function write lost");

  property p_pb9_addr;
    pclk_en && q.regs.pb_fu[3:2] == pbc_pkg::PBC_FN_10
      |=> pin_out.b[9] == $past(per_in.address_bit_twentyone) && pin_oe.b[9];
  endproperty
  a_pb9_addr: assert property (p_pb9_addr)
    else $error("pb9 not address 21");

  property p_pb8_wait;
    pclk_en && q.regs.pb_fu[1:0] == pbc_pkg::PBC_FN_11
      |=> per_out.wait_request_n == $past(q.sync2.b[8]) && !pin_oe.b[8];
  endproperty
  a_pb8_wait: assert property (p_pb8_wait)
    else $error("pb8 not wait input");

  property p_pb7_addr;
    pclk_en && q.regs.pb_fl[15:14] == pbc_pkg::PBC_FN_10
      |=> pin_out.b[7] == $past(per_in.address_bit_nineteen) && pin_oe.b[7];
  endproperty
  a_pb7_addr: assert property (p_pb7_addr)
    else $error("pb7 not address 19");

  property p_pb6_rsvd;
    pclk_en && q.regs.pb_fl[13:12] == pbc_pkg::PBC_FN_01 |=> !pin_oe.b[6];
  endproperty
  a_pb6_rsvd: assert property (p_pb6_rsvd)
    else $error("pb6 driven on reserved code");

  property p_pb3_interrupt_request_one;
    pclk_en && q.regs.pb_fl[6]
      |=> per_out.interrupt_request_one_n == $past(q.sync2.b[3]);
  endproperty
  a_pb3_interrupt_request_one: assert property (p_pb3_interrupt_request_one)
    else $error("pb3 not routed to interrupt_request_one");

  property p_pb1_addr;
    pclk_en && q.regs.pb_fl[2]
      |=> pin_out.b[1] == $past(per_in.address_bit_seventeen) && pin_oe.b[1];
  endproperty
  a_pb1_addr: assert property (p_pb1_addr)
    else $error("pb1 not address 17");

  property p_pb0_addr;
    pclk_en && q.regs.pb_fl[0]
      |=> pin_out.b[0] == $past(per_in.address_bit_sixteen) && pin_oe.b[0];
  endproperty
  a_pb0_addr: assert property (p_pb0_addr)
    else $error("pb0 not address 16");

  property p_pc_dir;
    pclk_en |=> pin_oe.c == $past(q.regs.pc_dir);
  endproperty
  a_pc_dir: assert property (p_pc_dir)
    else $error("port c direction not applied");

  property p_pc_dir_hold;
    pclk_en && !(psel && penable && pready && pwrite
                 && paddr == pbc_pkg::PBC_OFF_PC_DIR)
      |=> $stable(q.regs.pc_dir);
  endproperty
  a_pc_dir_hold: assert property (p_pc_dir_hold)
    else $error("port c direction changed without write");

  property p_apb_answer;
    s_apb_start |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("no answer after one wait state");

  property p_pb8_fn_dir;
    pclk_en && q.regs.pb_fu[1:0] != pbc_pkg::PBC_FN_GPIO
      |=> pin_oe.b[8] == ($past(q.regs.pb_fu[1:0]) == pbc_pkg::PBC_FN_10);
  endproperty
  a_pb8_fn_dir: assert property (p_pb8_fn_dir)
    else $error("pb8 direction bit not ignored");

endmodule // pbc_pin_function

// [pbc_pin_function_tb_top.sv]
// Purpose: self-checking bench for the port b/c pin function block
// Assumes: apb answer after one wait state; pins settle within 5 cycles
// Notes:   expectations come from register masks and function codes
`timescale 1ns/1ps
module pbc_pin_function_tb_top;
  logic                  pclk;      // bus clock, 100 MHz
  logic                  presetn;   // power-on reset, active low
  logic                  pclk_en;   // clock enable, dropped once
  logic                  psel;      // apb select
  logic                  penable;   // apb access phase
  logic                  pwrite;    // apb direction
  logic [7:0]            paddr;     // apb byte address
  logic [31:0]           pwdata;    // apb write data
  logic [31:0]           prdata;    // apb read data
  logic                  pready;    // apb answer
  logic                  pslverr;   // apb error
  pbc_pkg::pbc_pins_t    pin_in;    // pin levels from outside
  pbc_pkg::pbc_pins_t    pin_out;   // pin drive values
  pbc_pkg::pbc_pins_t    pin_oe;    // pin drive enables
  pbc_pkg::pbc_pins_t    gpio_dout; // gpio data to drive
  logic [15:0]           porta_dir; // port a direction bits
  pbc_pkg::pbc_pins_t    gpio_din;  // synced pin levels back
  pbc_pkg::pbc_per_in_t  per_in;    // peripheral outputs
  pbc_pkg::pbc_per_out_t per_out;   // peripheral inputs
  int                    err_total; // mismatches
  int                    tests_run; // comparisons
  // register table: offsets, writable masks, names
  localparam logic [7:0]  REG_OFF [5] = '{pbc_pkg::PBC_OFF_PA_FN,
    pbc_pkg::PBC_OFF_PB_DIR, pbc_pkg::PBC_OFF_PB_FU,
    pbc_pkg::PBC_OFF_PB_FL, pbc_pkg::PBC_OFF_PC_DIR};
  localparam logic [15:0] REG_MSK [5] = '{16'h0170, 16'h03FF, 16'h000F,
    16'hF045, 16'hFFFF};
  string                  reg_nm [5] = '{"porta_function",
    "port_b_direction", "port_b_function_upper", "port_b_function_lower",
    "port_c_direction"};

  pbc_pin_function dut_u (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .gpio_dout(gpio_dout),
    .porta_dir(porta_dir), .gpio_din(gpio_din), .per_in(per_in),
    .per_out(per_out)
  );

  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // value compare
  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // single-bit compare
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, 48'(e), 48'(g));
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      $display("unexpected pready expected 1 seen 0");
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // register write with expected error flag
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {16'h0000, d}, r, e);
    chk1("write pslverr", ee, e);
  endtask

  // register read and compare
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] ex, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, 48'(ex), 48'(r));
    chk1("read pslverr", ee, e);
  endtask

  // let pins and synchronisers settle
  task automatic settle;
    repeat (5) @(posedge pclk);
  endtask

  // all five read/write registers zero, pins idle
  task automatic t_zero;
    for (int i = 0; i < 5; i++) begin
      rd(reg_nm[i], REG_OFF[i], 32'h0, 1'b0);
    end
    chk("per_out idle", 48'h3F, 48'(per_out));
    chk("pin_oe idle", 48'h0, 48'(pin_oe));
  endtask

  // writable bits set, reserved left zero; unmapped and read-only places
  task automatic t_masks;
    for (int i = 0; i < 5; i++) begin
      wr(REG_OFF[i], REG_MSK[i], 1'b0);
      rd(reg_nm[i], REG_OFF[i], {16'h0, REG_MSK[i]}, 1'b0);
    end
    wr(pbc_pkg::PBC_OFF_PB_LEVEL, 16'hFFFF, 1'b0);
    wr(8'h1C, 16'hFFFF, 1'b1);
    rd("unmapped", 8'h1C, 32'h0, 1'b1);
  endtask

  // gpio direction and pin levels on ports b and c, two patterns
  task automatic t_dir;
    logic [15:0] db;
    logic [15:0] dc;
    for (int p = 0; p < 2; p++) begin
      db = p ? 16'h02AA : 16'h0155;
      dc = p ? 16'h5A5A : 16'hA5A5;
      gpio_dout <= p ? {3{16'hC3A5}} : {3{16'h3C5A}};
      pin_in    <= p ? {3{16'h9C63}} : {3{16'h639C}};
      wr(pbc_pkg::PBC_OFF_PB_DIR, db, 1'b0);
      wr(pbc_pkg::PBC_OFF_PC_DIR, dc, 1'b0);
      settle;
      chk("port b oe", 48'(db), 48'(pin_oe.b));
      chk("port b out", 48'(db & gpio_dout.b), 48'(db & pin_out.b));
      chk("port c oe", 48'(dc), 48'(pin_oe.c));
      chk("port c out", 48'(dc & gpio_dout.c), 48'(dc & pin_out.c));
      chk("port c din", 48'(pin_in.c), 48'(gpio_din.c));
      chk("port b din", 48'(pin_in.b & pbc_pkg::PBC_PINS_B),
          48'(gpio_din.b));
      rd("pb level", pbc_pkg::PBC_OFF_PB_LEVEL,
         {16'h0, pin_in.b & pbc_pkg::PBC_PINS_B}, 1'b0);
      rd("pc level", pbc_pkg::PBC_OFF_PC_LEVEL,
         {16'h0, pin_in.c}, 1'b0);
    end
  endtask

  // clock enable low: pins and registers hold while inputs move
  task automatic t_freeze;
    pbc_pkg::pbc_pins_t po;
    @(posedge pclk);
    pclk_en <= 1'b0;
    @(posedge pclk);
    po = pin_out;
    gpio_dout <= ~gpio_dout;
    settle;
    chk("frozen pin_out", 48'(po), 48'(pin_out));
    pclk_en <= 1'b1;
    settle;
    chk("thawed pin_out c", 48'(gpio_dout.c), 48'(pin_out.c));
    rd("port_c_direction", pbc_pkg::PBC_OFF_PC_DIR,
       32'h0000_5A5A, 1'b0);
  endtask

  // expected pin behaviour: 0 gpio, 1 input fn, 2 output fn, 3 reserved
  task automatic exp_pin(input string nm, input int k, input int gi,
                         input int ai, input int qi);
    logic q;
    q = (qi < 0) ? 1'b1 : per_out[qi];
    case (k)
      0: begin
        chk1({nm, " oe"}, 1'b1, pin_oe[gi]);
        chk1({nm, " out"}, gpio_dout[gi], pin_out[gi]);
        chk1({nm, " per"}, 1'b1, q);
      end
      1: begin
        chk1({nm, " oe"}, 1'b0, pin_oe[gi]);
        chk1({nm, " per"}, pin_in[gi], q);
      end
      2: begin
        chk1({nm, " oe"}, 1'b1, pin_oe[gi]);
        chk1({nm, " out"}, per_in[ai], pin_out[gi]);
        chk1({nm, " per"}, 1'b1, q);
      end
      default: begin
        chk1({nm, " oe"}, 1'b0, pin_oe[gi]);
        chk1({nm, " out"}, 1'b0, pin_out[gi]);
        chk1({nm, " per"}, 1'b1, q);
      end
    endcase
  endtask

  // every code of one function field, then back to gpio
  task automatic t_field(input string nm, input logic [7:0] off,
                         input int pos, input int nc, input int kd [4],
                         input int gi, input int ai, input int qi,
                         input int q3);
    for (int c = 0; c < nc; c++) begin
      wr(off, 16'(c << pos), 1'b0);
      settle;
      exp_pin(nm, kd[c], gi, ai, (c == 3) ? q3 : qi);
    end
    wr(off, 16'h0000, 1'b0);
  endtask

  // pin functions with all directions set to output
  task automatic t_pins;
    wr(pbc_pkg::PBC_OFF_PB_DIR, 16'h03FF, 1'b0);
    wr(pbc_pkg::PBC_OFF_PC_DIR, 16'hFFFF, 1'b0);
    for (int p = 0; p < 2; p++) begin
      @(posedge pclk);
      per_in    <= p ? 7'h2A : 7'h55;
      gpio_dout <= p ? {3{16'hA5A5}} : {3{16'h5A5A}};
      pin_in    <= p ? {3{16'hFFFF}} : {3{16'h0000}};
      porta_dir <= 16'hFFFF;
      t_field("pa4", 8'h00, 8, 2, '{0, 2, 0, 0}, 36, 6, -1, -1);
      t_field("pa3", 8'h00, 6, 2, '{0, 1, 0, 0}, 35, -1, 5, 5);
      t_field("pa2", 8'h00, 4, 4, '{0, 3, 3, 1}, 34, -1, 4, 4);
      t_field("pb9", 8'h08, 2, 4, '{0, 1, 2, 3}, 25, 0, 1, 1);
      t_field("pb8", 8'h08, 0, 4, '{0, 1, 2, 1}, 24, 1, 2, 0);
      t_field("pb7", 8'h0C, 14, 4, '{0, 3, 2, 3}, 23, 2, -1, -1);
      t_field("pb6", 8'h0C, 12, 4, '{0, 3, 2, 3}, 22, 3, -1, -1);
      t_field("pb3", 8'h0C, 6, 2, '{0, 1, 0, 0}, 19, -1, 3, 3);
      t_field("pb1", 8'h0C, 2, 2, '{0, 2, 0, 0}, 17, 4, -1, -1);
      t_field("pb0", 8'h0C, 0, 2, '{0, 2, 0, 0}, 16, 5, -1, -1);
    end
  endtask

  // main sequence
  initial begin
    err_total = 0;
    tests_run = 0;
    presetn   = 1'b0;
    pclk_en   = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    pin_in    = '0;
    gpio_dout = '0;
    porta_dir = 16'h0000;
    per_in    = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_zero;
    t_masks;
    // power-on reset after dirty registers
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_zero;
    t_dir;
    t_freeze;
    t_pins;
    summarize;
  end

  // hang guard, well beyond the expected run length
  initial begin
    #100000;
    err_total++;
    $display("unexpected watchdog expected finish seen timeout");
    summarize;
  end
endmodule // pbc_pin_function_tb_top
